/* File: core/csw_defs.svh */
// constants for the three-wire clocked serial channel
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

// ==========================================================
// register indices, byte address is four times the index
`define CSW_ADDR_W      18
`define CSW_IDX_W       16
`define CSW_IDX_MODE    16'hff60
`define CSW_IDX_BCTL    16'hff61
`define CSW_IDX_SHIFT   16'hff62
`define CSW_IDX_STAT    16'hff63
`define CSW_IDX_PORT    16'hff64

// ==========================================================
// reset values
`define CSW_MODE_RST    8'h00
`define CSW_BCTL_RST    8'h00
`define CSW_SHIFT_RST   8'h00
`define CSW_PORT_RST    8'h00

// ==========================================================
// field positions
`define CSW_BCTL_REL    0
`define CSW_BCTL_CMD    1
`define CSW_STAT_DONE   0
`define CSW_STAT_BUSY   1
`define CSW_STAT_SCK    2
`define CSW_STAT_SI     3
`define CSW_PORT_SCK_LAT 0
`define CSW_PORT_SCK_OE 1
`define CSW_PORT_SO_LAT 2
`define CSW_PORT_SO_OE  3
`define CSW_PORT_SI_LAT 4
`define CSW_PORT_SI_OE  5

// ==========================================================
// frame
`define CSW_LAST_BIT    3'h7

`endif

/* File: core/csw_pkg.sv */
// types and helpers for the three-wire clocked serial channel
`include "csw_defs.svh"
package csw_pkg;

   typedef enum logic {CSW_IDLE, CSW_SHIFT} csw_state_e;

   typedef struct packed {
      logic       en;
      logic       col;
      logic       wake;
      logic [1:0] mode_sel;
      logic       order_lsb;
      logic       cs_hi;
      logic       cs_lo;
   } csw_mode_s;

   typedef struct packed {
      logic o;
      logic oe;
   } csw_pad_s;

   function automatic logic [7:0] csw_rev8(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction

   function automatic logic [`CSW_ADDR_W-1:0] csw_byte_addr(input logic [`CSW_IDX_W-1:0] idx);
      return {idx, 2'b00};
   endfunction

endpackage

/* File: core/csw_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module csw_pin_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;
   logic rise_q;
   logic fall_q;

   // ========================================================
   // change counts once stages two and three agree
   wire agree = (s2_q == s3_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q   <= 1'b1;
         s2_q   <= 1'b1;
         s3_q   <= 1'b1;
         lvl_q  <= 1'b1;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         s1_q   <= pin;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         lvl_q  <= agree ? s3_q : lvl_q;
         rise_q <= agree & s3_q & ~lvl_q;
         fall_q <= agree & ~s3_q & lvl_q;
      end
   end

   assign level = lvl_q;
   assign rise  = rise_q;
   assign fall  = fall_q;
endmodule

/* File: core/csw_serial_top.sv */
// three-wire clocked serial channel with apb register access
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "csw_defs.svh"
module csw_serial_top
   import csw_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`CSW_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   timer_two_output,
   input  wire logic                   timer_clock_tick,
   input  wire logic                   sck_i,
   input  wire logic                   si_i,
   output csw_pad_s                    sck_pad,
   output csw_pad_s                    so_pad,
   output csw_pad_s                    si_pad,
   output logic                        transfer_done_flag
);

   // ========================================================
   // state
   csw_mode_s  mode_q;
   logic [5:0] bctl_hi_q;
   logic       rel_q;
   logic       cmd_q;
   logic [7:0] sr_q;
   logic [7:0] port_q;
   logic       so_latch_q;
   logic       flag_q;
   logic       sck_int_q;
   logic [2:0] bit_cnt_q;
   csw_state_e state_q;
   csw_state_e state_d;
   logic       pready_q;
   logic       pslverr_q;
   logic [31:0] prdata_q;
   csw_pad_s   sck_pad_q;
   csw_pad_s   so_pad_q;
   csw_pad_s   si_pad_q;

   // ========================================================
   // synchronised pins
   logic sck_lvl;
   logic sck_rise;
   logic sck_fall;
   logic si_lvl;

   csw_pin_sync u_sck_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (sck_i),
      .level   (sck_lvl),
      .rise    (sck_rise),
      .fall    (sck_fall)
   );

   csw_pin_sync u_si_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (si_i),
      .level   (si_lvl),
      .rise    (),
      .fall    ()
   );

   // ========================================================
   // bus decode
   wire       acc       = psel & penable;
   wire       hit_mode  = (paddr == csw_byte_addr(`CSW_IDX_MODE));
   wire       hit_bctl  = (paddr == csw_byte_addr(`CSW_IDX_BCTL));
   wire       hit_shift = (paddr == csw_byte_addr(`CSW_IDX_SHIFT));
   wire       hit_stat  = (paddr == csw_byte_addr(`CSW_IDX_STAT));
   wire       hit_port  = (paddr == csw_byte_addr(`CSW_IDX_PORT));
   wire       mapped    = hit_mode | hit_bctl | hit_shift | hit_stat | hit_port;
   wire       wr_fire   = acc & pwrite & pready_q & mapped;
   wire       wr_mode   = wr_fire & hit_mode;
   wire       wr_bctl   = wr_fire & hit_bctl;
   wire       wr_shift  = wr_fire & hit_shift;
   wire       wr_stat   = wr_fire & hit_stat;
   wire       wr_port   = wr_fire & hit_port;
   wire [7:0] wbyte     = pwdata[7:0];

   // ========================================================
   // serial clock selection and events
   wire en       = mode_q.en;
   wire busy     = (state_q == CSW_SHIFT);
   wire ext_clk  = ~mode_q.cs_hi;
   wire int_tick = mode_q.cs_lo ? timer_clock_tick : timer_two_output;
   wire int_ev   = busy & ~ext_clk & int_tick;
   wire fall_ev  = busy & (ext_clk ? sck_fall : (int_ev & sck_int_q));
   wire rise_ev  = busy & (ext_clk ? sck_rise : (int_ev & ~sck_int_q));
   wire last_ev  = rise_ev & (bit_cnt_q == `CSW_LAST_BIT);
   wire start_ok = en & ~busy & (~ext_clk | sck_lvl);
   wire start    = wr_shift & start_ok;
   wire [7:0] wr_order = mode_q.order_lsb ? csw_rev8(wbyte) : wbyte;
   wire [7:0] rd_order = mode_q.order_lsb ? csw_rev8(sr_q) : sr_q;

   // ========================================================
   // transfer state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CSW_IDLE: begin
            if (start) begin
               state_d = CSW_SHIFT;
            end
         end
         CSW_SHIFT: begin
            if (!en || last_ev) begin
               state_d = CSW_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CSW_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ========================================================
   // internal clock and bit count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_int_q <= 1'b1;
         bit_cnt_q <= 3'h0;
      end else begin
         sck_int_q <= busy ? (sck_int_q ^ int_ev) : 1'b1;
         if (start) begin
            bit_cnt_q <= 3'h0;
         end else if (rise_ev) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
         end
      end
   end

   // ========================================================
   // shift register and output latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_q <= `CSW_SHIFT_RST;
      end else if (wr_shift && !busy) begin
         sr_q <= wr_order;
      end else if (rise_ev) begin
         sr_q[0] <= si_lvl;
      end else if (fall_ev) begin
         sr_q <= {sr_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         so_latch_q <= 1'b0;
      end else if (fall_ev) begin
         so_latch_q <= sr_q[7];
      end else if (rel_q) begin
         so_latch_q <= 1'b1;
      end else if (cmd_q) begin
         so_latch_q <= 1'b0;
      end
   end

   // ========================================================
   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q    <= `CSW_MODE_RST;
         bctl_hi_q <= 6'h00;
         rel_q     <= 1'b0;
         cmd_q     <= 1'b0;
         port_q    <= `CSW_PORT_RST;
      end else begin
         if (wr_mode) begin
            mode_q <= {wbyte[7], mode_q.col, wbyte[5:0]};
         end
         if (wr_bctl) begin
            bctl_hi_q <= wbyte[7:2];
         end
         rel_q <= en & wr_bctl & wbyte[`CSW_BCTL_REL];
         cmd_q <= en & wr_bctl & wbyte[`CSW_BCTL_CMD];
         if (wr_port) begin
            port_q <= wbyte;
         end
      end
   end

   // ========================================================
   // done flag, set wins over write-one clear
   wire flag_clr = wr_stat & wbyte[`CSW_STAT_DONE];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= last_ev | (flag_q & ~flag_clr);
      end
   end

   // ========================================================
   // pin drivers
   wire sck_o_w  = (busy & ~ext_clk) ? sck_int_q : port_q[`CSW_PORT_SCK_LAT];
   wire sck_oe_w = en ? ~ext_clk : port_q[`CSW_PORT_SCK_OE];
   wire so_o_w   = en ? so_latch_q : port_q[`CSW_PORT_SO_LAT];
   wire so_oe_w  = en | port_q[`CSW_PORT_SO_OE];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_pad_q <= '{o: 1'b0, oe: 1'b0};
         so_pad_q  <= '{o: 1'b0, oe: 1'b0};
         si_pad_q  <= '{o: 1'b0, oe: 1'b0};
      end else begin
         sck_pad_q <= '{o: sck_o_w, oe: sck_oe_w};
         so_pad_q  <= '{o: so_o_w, oe: so_oe_w};
         si_pad_q  <= '{o: port_q[`CSW_PORT_SI_LAT], oe: port_q[`CSW_PORT_SI_OE]};
      end
   end

   // ========================================================
   // apb answer, one wait state
   logic [7:0] rbyte;
   always_comb begin
      rbyte = 8'h00;
      if (hit_mode) begin
         rbyte = mode_q;
      end else if (hit_bctl) begin
         rbyte = {bctl_hi_q, cmd_q, rel_q};
      end else if (hit_shift) begin
         rbyte = rd_order;
      end else if (hit_stat) begin
         rbyte = {4'h0, si_lvl, sck_lvl, busy, flag_q};
      end else if (hit_port) begin
         rbyte = port_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= acc & ~pready_q;
         pslverr_q <= acc & ~pready_q & ~mapped;
         prdata_q  <= (acc & ~pready_q & ~pwrite) ? {24'h00_0000, rbyte} : 32'h0000_0000;
      end
   end

   assign prdata             = prdata_q;
   assign pready             = pready_q;
   assign pslverr            = pslverr_q;
   assign sck_pad            = sck_pad_q;
   assign so_pad             = so_pad_q;
   assign si_pad             = si_pad_q;
   assign transfer_done_flag = flag_q;

   // ========================================================
   // checks
   chk_col_read_only: assert property (@(posedge pclk) disable iff (!presetn)
      wr_mode && wbyte[6] |=> !mode_q.col)
      else $error("collision indicator changed by a write");

   chk_disable_stops: assert property (@(posedge pclk) disable iff (!presetn)
      !en |=> !busy)
      else $error("transfer running while channel disabled");

   chk_release_sets: assert property (@(posedge pclk) disable iff (!presetn)
      en && wr_bctl && wbyte[0] && !busy ##1 !fall_ev |=> so_latch_q && !rel_q)
      else $error("release trigger did not set output latch");

   chk_command_clears: assert property (@(posedge pclk) disable iff (!presetn)
      en && wr_bctl && wbyte[1] && !wbyte[0] && !busy ##1 !fall_ev |=> !so_latch_q && !cmd_q)
      else $error("command trigger did not clear output latch");

   chk_trigger_forced: assert property (@(posedge pclk) disable iff (!presetn)
      !en |=> !rel_q && !cmd_q)
      else $error("trigger bit set while channel disabled");

   chk_shift_falling: assert property (@(posedge pclk) disable iff (!presetn)
      fall_ev |=> so_latch_q == $past(sr_q[7]) && sr_q[7:1] == $past(sr_q[6:0]))
      else $error("falling edge did not shift out");

   chk_sample_rising: assert property (@(posedge pclk) disable iff (!presetn)
      rise_ev && !wr_shift |=> sr_q[0] == $past(si_lvl))
      else $error("rising edge did not capture input");

   chk_done_eighth: assert property (@(posedge pclk) disable iff (!presetn)
      busy && rise_ev && bit_cnt_q == 3'h7 |=> !busy && transfer_done_flag)
      else $error("eighth bit did not end the frame");

   chk_no_early_end: assert property (@(posedge pclk) disable iff (!presetn)
      busy && en && !(rise_ev && bit_cnt_q == 3'h7) |=> busy)
      else $error("frame ended before eight bits");

   chk_start_gate: assert property (@(posedge pclk) disable iff (!presetn)
      wr_shift && !en && !busy |=> !busy)
      else $error("write started a transfer while disabled");

   chk_idle_clock: assert property (@(posedge pclk) disable iff (!presetn)
      en && !ext_clk && !busy ##1 en && !ext_clk && !busy |=> sck_pad.o == $past(port_q[0]))
      else $error("idle clock level not from port latch");

   chk_bit_order: assert property (@(posedge pclk) disable iff (!presetn)
      wr_shift && !busy && mode_q.order_lsb |=> sr_q == csw_rev8($past(wbyte)))
      else $error("lsb-first write not reversed");

endmodule

/* File: testbench/csw_peer.sv */
// serial peripheral peer that follows or makes the link clock
`timescale 1ns/1ps
module csw_peer (
   input  wire logic sck_w,
   input  wire logic so_w,
   output logic      si_o,
   output logic      sck_o
);
   logic [7:0] tx_q  = 8'h00;
   logic [7:0] rx_q  = 8'h00;
   int         nbits = 0;

   initial begin
      si_o = 1'b0;
      sck_o = 1'b1;
   end

   task automatic load(input logic [7:0] tx);
      tx_q = tx;
      nbits = 0;
   endtask

   // ==========================================
   // link clock, high between frames, phase unrelated to pclk
   task automatic run_clock();
      #7.3;
      repeat (8) begin
         sck_o = 1'b0;
         #100;
         sck_o = 1'b1;
         #100;
      end
   endtask

   // ==========================================
   // next bit out on the falling edge, msb first
   always @(negedge sck_w) begin
      si_o = tx_q[7];
      tx_q = {tx_q[6:0], 1'b0};
   end

   // output taken late in the high phase, then the held bit runs out
   always @(posedge sck_w) begin
      #90;
      rx_q = {rx_q[6:0], so_w};
      nbits++;
      si_o = ~si_o;
   end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the three-wire clocked serial channel
`timescale 1ns/1ps
`include "csw_defs.svh"
module tb
   import csw_pkg::*;
();
   logic                   pclk, presetn, psel, penable, pwrite;
   logic                   timer_two_output = 1'b0;
   logic                   timer_clock_tick = 1'b0;
   logic [`CSW_ADDR_W-1:0] paddr;
   logic [31:0]            pwdata, prdata, rd;
   logic [31:0]            rnd = 32'h6bce;
   logic                   pready, pslverr, transfer_done_flag, err;
   logic                   sck_w, so_w, si_w, peer_si, peer_sck;
   logic [7:0]             b, t;
   logic [2:0]             tick_cnt = 3'h0;
   csw_pad_s               sck_pad, so_pad, si_pad;
   int                     error_cnt = 0;
   int                     n_tests = 0;
   int                     cyc = 0;
   int                     tick_en = 0;

   assign sck_w = sck_pad.oe ? sck_pad.o : peer_sck;
   assign so_w  = so_pad.oe ? so_pad.o : ~so_pad.o;
   assign si_w  = si_pad.oe ? si_pad.o : peer_si;

   csw_serial_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_two_output(timer_two_output), .timer_clock_tick(timer_clock_tick), .sck_i(sck_w),
      .si_i(si_w), .sck_pad(sck_pad), .so_pad(so_pad), .si_pad(si_pad),
      .transfer_done_flag(transfer_done_flag));

   csw_peer peer (.sck_w(sck_w), .so_w(so_w), .si_o(peer_si), .sck_o(peer_sck));

   // ==========================================
   // clock, timer ticks, timeout
   always #12.5 pclk = ~pclk;

   always @(posedge pclk) begin
      tick_cnt <= tick_cnt + 3'h1;
      timer_two_output <= (tick_en == 1) && (tick_cnt == 3'h0);
      timer_clock_tick <= (tick_en == 2) && (tick_cnt == 3'h0);
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // ==========================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] rev(input logic [7:0] v);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) r[i] = v[7-i];
      return r;
   endfunction

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [`CSW_IDX_W-1:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) chk("pready", 1, 0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [`CSW_IDX_W-1:0] idx, input logic [7:0] ex);
      apb(1'b0, idx, 8'h00);
      chk(nm, {24'h000000, ex}, rd);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================
   // one frame: src 0 external, 1 timer two, 2 timer clock
   task automatic frame(input logic lsb, input int src);
      int n;
      n = 0;
      repeat (16) rnd = lfsr(rnd);
      b = rnd[7:0];
      t = rnd[15:8];
      apb(1'b1, `CSW_IDX_MODE, {5'b10000, lsb, src != 0, src == 2});
      peer.load(t);
      apb(1'b1, `CSW_IDX_SHIFT, b);
      if (src == 0) begin
         apb(1'b1, `CSW_IDX_SHIFT, ~b);
         peer.run_clock();
      end
      tick_en <= src;
      while (transfer_done_flag !== 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      tick_en <= 0;
      repeat (6) @(posedge pclk);
      chk("flag", 1, transfer_done_flag);
      chk("bits", 8, peer.nbits);
      chk("sent", lsb ? rev(b) : b, peer.rx_q);
      if (src == 0) peer.run_clock();
      rdchk("received", `CSW_IDX_SHIFT, lsb ? rev(t) : t);
      if (src != 0) chk("sck idle", 1, sck_pad.o);
      apb(1'b1, `CSW_IDX_STAT, 8'h01);
      @(posedge pclk);
      chk("flag clear", 0, transfer_done_flag);
   endtask

   // ==========================================
   // main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h00000000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("mode rst", `CSW_IDX_MODE, 8'h00);
      rdchk("bus ctl rst", `CSW_IDX_BCTL, 8'h00);
      apb(1'b1, `CSW_IDX_MODE, 8'hff);
      rdchk("mode ro", `CSW_IDX_MODE, 8'hbf);
      apb(1'b1, `CSW_IDX_MODE, 8'h00);
      apb(1'b0, 16'hff70, 8'h00);
      chk("slverr", 1, err);
      apb(1'b1, `CSW_IDX_BCTL, 8'hfc);
      rdchk("bus ctl store", `CSW_IDX_BCTL, 8'hfc);
      apb(1'b1, `CSW_IDX_BCTL, 8'h01);
      rdchk("trig off", `CSW_IDX_BCTL, 8'h00);
      apb(1'b1, `CSW_IDX_SHIFT, 8'h5a);
      peer.run_clock();
      rdchk("plain shift", `CSW_IDX_SHIFT, 8'h5a);
      apb(1'b1, `CSW_IDX_MODE, 8'h80);
      apb(1'b0, `CSW_IDX_STAT, 8'h00);
      chk("late start", 0, rd[1:0]);
      // triggers used only outside transfers
      apb(1'b1, `CSW_IDX_BCTL, 8'h01);
      repeat (3) @(posedge pclk);
      chk("rel latch", 1, so_pad.o);
      apb(1'b1, `CSW_IDX_BCTL, 8'h02);
      repeat (3) @(posedge pclk);
      chk("cmd latch", 0, so_pad.o);
      rdchk("trig clear", `CSW_IDX_BCTL, 8'h00);
      apb(1'b1, `CSW_IDX_PORT, 8'h01);
      for (int k = 0; k < 6; k++) frame(k[0], k / 2);
      apb(1'b1, `CSW_IDX_MODE, 8'h82);
      apb(1'b1, `CSW_IDX_PORT, 8'h00);
      repeat (3) @(posedge pclk);
      chk("sck latch", 0, sck_pad.o);
      apb(1'b1, `CSW_IDX_MODE, 8'h00);
      apb(1'b1, `CSW_IDX_BCTL, 8'h02);
      rdchk("cmd off", `CSW_IDX_BCTL, 8'h00);
      apb(1'b1, `CSW_IDX_PORT, 8'h3c);
      repeat (3) @(posedge pclk);
      chk("so port", 2'b11, so_pad);
      chk("si port", 2'b11, si_pad);
      give_verdict();
   end
endmodule
